/* File: hw/rhc_pkg.sv */
// Shared constants and carrier types for the humidity sensor command core.
// Assumes a byte-level bus front end that decodes addressing and ACK timing.
package rhc_pkg;

   // ******************************************************************
   // Command codes
   // ******************************************************************
   localparam logic [7:0] CMD_MEAS_HIGH   = 8'hFD;
   localparam logic [7:0] CMD_MEAS_MED    = 8'hF6;
   localparam logic [7:0] CMD_MEAS_LOW    = 8'hE0;
   localparam logic [7:0] CMD_SERIAL      = 8'h89;
   localparam logic [7:0] CMD_SOFT_RESET  = 8'h94;
   localparam logic [7:0] CMD_H200_LONG   = 8'h39;
   localparam logic [7:0] CMD_H200_SHORT  = 8'h32;
   localparam logic [7:0] CMD_H110_LONG   = 8'h2F;
   localparam logic [7:0] CMD_H110_SHORT  = 8'h24;
   localparam logic [7:0] CMD_H20_LONG    = 8'h1E;
   localparam logic [7:0] CMD_H20_SHORT   = 8'h15;
   localparam logic [7:0] CMD_GC_RESET    = 8'h06;

   // ******************************************************************
   // Heater power levels and checksum
   // ******************************************************************
   localparam logic [1:0] PWR_OFF         = 2'h0;
   localparam logic [1:0] PWR_20MW        = 2'h1;
   localparam logic [1:0] PWR_110MW       = 2'h2;
   localparam logic [1:0] PWR_200MW       = 2'h3;
   localparam logic [7:0] CRC_POLY        = 8'h31;
   localparam logic [7:0] CRC_INIT        = 8'hFF;
   localparam logic [7:0] IDLE_BYTE       = 8'hFF;
   localparam logic [2:0] RESP_BYTES      = 3'h6;

   // ******************************************************************
   // Timing
   // ******************************************************************
   localparam int         CLK_PERIOD_NS   = 20;
   localparam int         HEAT_LONG_NS    = 1_000_000_000;
   localparam int         HEAT_SHORT_NS   = 100_000_000;
   localparam logic [25:0] HEAT_LONG_CYC  = 26'(HEAT_LONG_NS / CLK_PERIOD_NS);
   localparam logic [25:0] HEAT_SHORT_CYC = 26'(HEAT_SHORT_NS / CLK_PERIOD_NS);
   localparam logic [25:0] CNT_ONE        = 26'h0000001;

   // ******************************************************************
   // Carrier types
   // ******************************************************************
   typedef struct packed {
      logic       valid;    // One-cycle pulse per received command byte
      logic       gencall;  // Byte came in on the general call address
      logic [7:0] code;
   } rhc_cmd_t;

   typedef struct packed {
      logic        done;    // One-cycle pulse from the measurement engine
      logic [15:0] temp;
      logic [15:0] hum;     // humidity_raw_word
   } rhc_meas_t;

   typedef struct packed {
      logic       en;
      logic [1:0] pwr;
   } rhc_heat_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } rhc_byte_t;

endpackage : rhc_pkg

/* File: hw/rhc_crc8.sv */
// Combinational CRC-8 over one 16-bit word, MSB first.
// Assumes the caller registers the result where timing matters.
`timescale 1ns/1ns
module rhc_crc8 (
   input  wire logic [15:0] i_word,
   output logic      [7:0]  o_crc
);

   // ******************************************************************
   // Bitwise shift loop, no reflection and no final XOR
   // ******************************************************************
   always_comb begin
      logic [7:0] c;
      c = rhc_pkg::CRC_INIT;
      for (int b = 15; b >= 0; b--) begin
         if (c[7] ^ i_word[b]) begin
            c = {c[6:0], 1'b0} ^ rhc_pkg::CRC_POLY;
         end else begin
            c = {c[6:0], 1'b0};
         end
      end
      o_crc = c;
   end

endmodule : rhc_crc8

/* File: hw/rhc_core.sv */
// Command core of a humidity and temperature sensor: heater sequencing,
// reset and abort, serial number and result readout with checksums.
// Assumes a bus front end that delivers command bytes, read headers and
// byte requests as one-cycle pulses, and a measurement engine with a done pulse.
//
// Overview of operation
// - Serial number fixed, no command changes it.
// - Serial returns two words, each with checksum.
// - Soft reset command to own address resets.
// - General call byte 0x06 resets device.
// - Power removal gives full reset.
// - Any reset abandons running measurement or heating.
// - Heater command turns heater on, starts countdown.
// - Countdown expiry starts high measurement, heater on.
// - Heater off after measurement; results become readable.
// - Three powers, two durations, one command each.
// - Heater countdown at most one second, no off command.
// - Busy device refuses read header, never stretches.
// - Checksum CRC-8, poly 0x31, init 0xFF.
// - Heater codes 0x39..0x15, six-byte answer each.
`timescale 1ns/1ns
module rhc_core #(
   parameter logic [25:0] HEAT_LONG_CYC  = rhc_pkg::HEAT_LONG_CYC,
   parameter logic [25:0] HEAT_SHORT_CYC = rhc_pkg::HEAT_SHORT_CYC,
   parameter logic [31:0] SERIAL_NUM     = 32'h1234_5678 // Arbitrary value
) (
   input  wire logic               I_CLK,
   input  wire logic               I_RST,
   input  wire rhc_pkg::rhc_cmd_t  I_CMD,
   input  wire logic               I_RD_HDR,
   input  wire logic               I_BYTE_REQ,
   input  wire rhc_pkg::rhc_meas_t I_MEAS,
   output logic                    O_HDR_ACK,
   output logic                    O_HDR_NACK,
   output rhc_pkg::rhc_byte_t      O_BYTE,
   output rhc_pkg::rhc_heat_t      O_HEAT,
   output logic                    O_MEAS_START,
   output logic                    O_BUSY
);

   // ******************************************************************
   // State and storage
   // ******************************************************************
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_HEAT  = 3'b001,
      ST_HMEAS = 3'b010,
      ST_MEAS  = 3'b011,
      ST_READY = 3'b100
   } rhc_state_t;

   rhc_state_t         state_ff,  nxt_state;
   rhc_pkg::rhc_heat_t heat_ff,   nxt_heat;
   logic [25:0]        cnt_ff,    nxt_cnt;
   logic [15:0]        res_ff [2];
   logic [15:0]        nxt_res [2];
   logic [47:0]        tx_ff,     nxt_tx;
   logic [2:0]         left_ff,   nxt_left;
   rhc_pkg::rhc_byte_t byte_ff,   nxt_byte;
   logic               ack_ff,    nxt_ack;
   logic               nack_ff,   nxt_nack;
   logic               mstart_ff, nxt_mstart;
   logic               busy_ff,   nxt_busy;
   logic [7:0]         crc_w [2];
   logic               do_reset;
   logic               own_cmd;

   // ******************************************************************
   // One checksum per result word
   // ******************************************************************
   generate
      for (genvar w = 0; w < 2; w++) begin : g_crc
         rhc_crc8 u_crc (
            .i_word (res_ff[w]),
            .o_crc  (crc_w[w])
         );
      end
   endgenerate

   // Reset decode: own-address soft reset or general call reset
   assign do_reset = I_CMD.valid &
                     ((~I_CMD.gencall & (I_CMD.code == rhc_pkg::CMD_SOFT_RESET)) |
                      (I_CMD.gencall & (I_CMD.code == rhc_pkg::CMD_GC_RESET)));
   // General call bytes other than reset are not ours
   assign own_cmd  = I_CMD.valid & ~I_CMD.gencall;

   // ******************************************************************
   // Next-state logic
   // ******************************************************************
   always_comb begin
      nxt_state  = state_ff;
      nxt_heat   = heat_ff;
      nxt_cnt    = cnt_ff;
      nxt_res    = res_ff;
      nxt_tx     = tx_ff;
      nxt_left   = left_ff;
      nxt_ack    = 1'b0;
      nxt_nack   = 1'b0;
      nxt_mstart = 1'b0;
      nxt_byte   = '{valid: 1'b0, data: rhc_pkg::IDLE_BYTE};
      // Byte readout runs independently of the command sequencer
      if (I_BYTE_REQ) begin
         nxt_byte.valid = 1'b1;
         if (left_ff != 3'h0) begin
            nxt_byte.data = tx_ff[47:40];
            nxt_tx        = {tx_ff[39:0], rhc_pkg::IDLE_BYTE};
            nxt_left      = left_ff - 3'h1;
         end
      end
      if (do_reset) begin
         // Abort wins over everything; ACK itself comes from the front end
         nxt_state = ST_IDLE;
         nxt_heat  = '{en: 1'b0, pwr: rhc_pkg::PWR_OFF};
         nxt_cnt   = '0;
         nxt_left  = 3'h0;
      end else begin
         case (state_ff)
            ST_IDLE, ST_READY: begin
               if (own_cmd) begin
                  case (I_CMD.code)
                     rhc_pkg::CMD_MEAS_HIGH, rhc_pkg::CMD_MEAS_MED,
                     rhc_pkg::CMD_MEAS_LOW: begin
                        nxt_state  = ST_MEAS;
                        nxt_mstart = 1'b1;
                     end
                     rhc_pkg::CMD_SERIAL: begin
                        nxt_res[0] = SERIAL_NUM[31:16];
                        nxt_res[1] = SERIAL_NUM[15:0];
                        nxt_state  = ST_READY;
                     end
                     rhc_pkg::CMD_H200_LONG, rhc_pkg::CMD_H200_SHORT,
                     rhc_pkg::CMD_H110_LONG, rhc_pkg::CMD_H110_SHORT,
                     rhc_pkg::CMD_H20_LONG,  rhc_pkg::CMD_H20_SHORT: begin
                        nxt_state   = ST_HEAT;
                        nxt_heat.en = 1'b1;
                        // Power from the upper code group, duration from the pair
                        case (I_CMD.code)
                           rhc_pkg::CMD_H200_LONG, rhc_pkg::CMD_H200_SHORT:
                              nxt_heat.pwr = rhc_pkg::PWR_200MW;
                           rhc_pkg::CMD_H110_LONG, rhc_pkg::CMD_H110_SHORT:
                              nxt_heat.pwr = rhc_pkg::PWR_110MW;
                           default:
                              nxt_heat.pwr = rhc_pkg::PWR_20MW;
                        endcase
                        if (I_CMD.code == rhc_pkg::CMD_H200_LONG ||
                            I_CMD.code == rhc_pkg::CMD_H110_LONG ||
                            I_CMD.code == rhc_pkg::CMD_H20_LONG) begin
                           nxt_cnt = HEAT_LONG_CYC;
                        end else begin
                           nxt_cnt = HEAT_SHORT_CYC;
                        end
                     end
                     default: ;
                  endcase
               end else if (I_RD_HDR) begin
                  if (state_ff == ST_READY) begin
                     // Result handed out once, then gone
                     nxt_ack   = 1'b1;
                     nxt_state = ST_IDLE;
                     nxt_tx    = {res_ff[0], crc_w[0], res_ff[1], crc_w[1]};
                     nxt_left  = rhc_pkg::RESP_BYTES;
                  end else begin
                     nxt_nack  = 1'b1;
                  end
               end
            end
            ST_HEAT: begin
               // Countdown only; no command can stop it but a reset
               nxt_cnt = cnt_ff - rhc_pkg::CNT_ONE;
               if (cnt_ff == rhc_pkg::CNT_ONE) begin
                  nxt_state  = ST_HMEAS;
                  nxt_mstart = 1'b1;
               end
               nxt_nack = I_RD_HDR;
            end
            ST_HMEAS, ST_MEAS: begin
               if (I_MEAS.done) begin
                  nxt_heat  = '{en: 1'b0, pwr: rhc_pkg::PWR_OFF};
                  nxt_res[0] = I_MEAS.temp;
                  nxt_res[1] = I_MEAS.hum;
                  nxt_state  = ST_READY;
               end
               nxt_nack = I_RD_HDR;
            end
            default: nxt_state = ST_IDLE;
         endcase
      end
      // Busy is registered from the next state so the port comes from a flop
      nxt_busy = (nxt_state == ST_HEAT) || (nxt_state == ST_HMEAS) ||
                 (nxt_state == ST_MEAS);
   end

   // ******************************************************************
   // Registers; power-down reset clears all
   // ******************************************************************
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         state_ff  <= ST_IDLE;
         heat_ff   <= '{en: 1'b0, pwr: rhc_pkg::PWR_OFF};
         cnt_ff    <= '0;
         res_ff    <= '{16'h0000, 16'h0000};
         tx_ff     <= '0;
         left_ff   <= 3'h0;
         byte_ff   <= '{valid: 1'b0, data: rhc_pkg::IDLE_BYTE};
         ack_ff    <= 1'b0;
         nack_ff   <= 1'b0;
         mstart_ff <= 1'b0;
         busy_ff   <= 1'b0;
      end else begin
         state_ff  <= nxt_state;
         heat_ff   <= nxt_heat;
         cnt_ff    <= nxt_cnt;
         res_ff    <= nxt_res;
         tx_ff     <= nxt_tx;
         left_ff   <= nxt_left;
         byte_ff   <= nxt_byte;
         ack_ff    <= nxt_ack;
         nack_ff   <= nxt_nack;
         mstart_ff <= nxt_mstart;
         busy_ff   <= nxt_busy;
      end
   end

   assign O_HEAT       = heat_ff;
   assign O_BYTE       = byte_ff;
   assign O_HDR_ACK    = ack_ff;
   assign O_HDR_NACK   = nack_ff;
   assign O_MEAS_START = mstart_ff;
   assign O_BUSY       = busy_ff;

   // ******************************************************************
   // Checks
   // ******************************************************************
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RST);

   chk_reset_abort: assert property (
      do_reset |=> state_ff == ST_IDLE && !heat_ff.en && left_ff == 3'h0)
      else $error("Reset did not abort activity");
   chk_gencall_reset: assert property (
      I_CMD.valid && I_CMD.gencall && I_CMD.code == rhc_pkg::CMD_GC_RESET
      |=> state_ff == ST_IDLE && !O_MEAS_START)
      else $error("General call reset ignored");
   chk_heat_start: assert property (
      own_cmd && !O_BUSY && I_CMD.code == rhc_pkg::CMD_H110_SHORT
      |=> heat_ff.en && heat_ff.pwr == rhc_pkg::PWR_110MW && cnt_ff == HEAT_SHORT_CYC)
      else $error("Heater command not started");
   chk_heat_expire: assert property (
      state_ff == ST_HEAT && cnt_ff == rhc_pkg::CNT_ONE && !do_reset
      |=> O_MEAS_START && heat_ff.en && state_ff == ST_HMEAS)
      else $error("Countdown expiry did not start measurement");
   chk_heat_end: assert property (
      state_ff == ST_HMEAS && I_MEAS.done && !do_reset
      |=> !heat_ff.en && state_ff == ST_READY && res_ff[0] == $past(I_MEAS.temp))
      else $error("Heater not off after measurement");
   chk_heat_limit: assert property (
      state_ff == ST_HEAT |-> cnt_ff <= HEAT_LONG_CYC && cnt_ff != 26'h0000000)
      else $error("Heater countdown out of range");
   chk_busy_nack: assert property (
      O_BUSY && I_RD_HDR && !do_reset |=> O_HDR_NACK && !O_HDR_ACK)
      else $error("Busy device did not refuse header");
   chk_tx_crc: assert property (
      O_HDR_ACK |-> tx_ff[31:24] == crc_w[0] && tx_ff[7:0] == crc_w[1])
      else $error("Checksum byte mismatch");
   chk_serial_words: assert property (
      own_cmd && !O_BUSY && I_CMD.code == rhc_pkg::CMD_SERIAL && !do_reset
      |=> res_ff[0] == SERIAL_NUM[31:16] && res_ff[1] == SERIAL_NUM[15:0])
      else $error("Serial words wrong");

   cov_heat_done: cover property (state_ff == ST_HMEAS ##1 state_ff == ST_READY);
   cov_read_ack:  cover property (O_HDR_ACK ##[1:20] O_BYTE.valid);
   cov_nack:      cover property (O_HDR_NACK);
   cov_heat_abrt: cover property (state_ff == ST_HEAT && do_reset);

endmodule : rhc_core

/* File: test/rhc_meas_model.sv */
// Behavioural measurement engine facing the command core.
// Assumes start is a one-cycle pulse; answers after a chosen delay.
`timescale 1ns/1ns
module rhc_meas_model (
   input  wire logic         i_clk,
   input  wire logic         i_start,
   input  wire logic [15:0]  i_temp,
   input  wire logic [15:0]  i_hum,
   input  wire logic [3:0]   i_dly,
   output rhc_pkg::rhc_meas_t o_meas
);
   // ******************************************************************
   // Answer after i_dly edges, then let the words go stale
   // ******************************************************************
   initial o_meas = '{1'b0, 16'h0000, 16'h0000};
   // Stale words are inverted so a late sample never matches by luck
   always @(posedge i_clk) begin
      if (i_start === 1'b1) begin
         repeat (i_dly) @(posedge i_clk);
         #2;
         o_meas = '{1'b1, i_temp, i_hum};
         @(posedge i_clk);
         #2;
         o_meas = '{1'b0, ~i_temp, ~i_hum};
      end
   end
endmodule : rhc_meas_model

/* File: test/rhc_core_tb.sv */
// Self-checking bench for the command core: heater runs, readout, resets.
// Assumes the measurement model stands in for the engine behind the core.
`timescale 1ns/1ns
module rhc_core_tb;
   localparam logic [25:0] NL = 26'h0000014;   // Long pulse, shortened
   localparam logic [25:0] NS = 26'h0000005;   // Short pulse, shortened
   localparam logic [31:0] SN = 32'hA5C3_0F96; // Arbitrary value
   logic               I_CLK;
   logic               I_RST;
   rhc_pkg::rhc_cmd_t  I_CMD;
   logic               I_RD_HDR;
   logic               I_BYTE_REQ;
   rhc_pkg::rhc_meas_t I_MEAS;
   logic               O_HDR_ACK;
   logic               O_HDR_NACK;
   rhc_pkg::rhc_byte_t O_BYTE;
   rhc_pkg::rhc_heat_t O_HEAT;
   logic               O_MEAS_START;
   logic               O_BUSY;
   logic [15:0]        temp;
   logic [15:0]        hum;
   logic [3:0]         dly;
   logic [9:0]         notes[$];
   logic [9:0]         seen;
   logic [7:0]         codes[6] = '{8'h39, 8'h32, 8'h2F, 8'h24, 8'h1E, 8'h15};
   logic [1:0]         pwrs[6] = '{2'h3, 2'h3, 2'h2, 2'h2, 2'h1, 2'h1};
   logic [7:0]         mcodes[3] = '{rhc_pkg::CMD_MEAS_HIGH, rhc_pkg::CMD_MEAS_MED,
                                     rhc_pkg::CMD_MEAS_LOW};
   integer             num_errors = 0;
   integer             tests_run = 0;
   integer             seed = 84081;
   integer             n;

   rhc_core #(.HEAT_LONG_CYC(NL), .HEAT_SHORT_CYC(NS), .SERIAL_NUM(SN)) rhc_core_i (
      .I_CLK(I_CLK), .I_RST(I_RST), .I_CMD(I_CMD), .I_RD_HDR(I_RD_HDR),
      .I_BYTE_REQ(I_BYTE_REQ), .I_MEAS(I_MEAS), .O_HDR_ACK(O_HDR_ACK),
      .O_HDR_NACK(O_HDR_NACK), .O_BYTE(O_BYTE), .O_HEAT(O_HEAT),
      .O_MEAS_START(O_MEAS_START), .O_BUSY(O_BUSY));
   rhc_meas_model rhc_meas_model_i (.i_clk(I_CLK), .i_start(O_MEAS_START),
      .i_temp(temp), .i_hum(hum), .i_dly(dly), .o_meas(I_MEAS));

   initial begin
      I_CLK = 1'b0;
      forever #10 I_CLK = ~I_CLK;
   end
   // ******************************************************************
   // Helpers
   // ******************************************************************
   task automatic tally_and_finish;
      if (num_errors == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // A wait that ran out leaves nothing sensible to check afterwards
   task automatic bound(input integer lim);
      if (n >= lim) begin
         num_errors++;
         $display("ERROR %0t got %h exp %h", $time, n, lim);
         tally_and_finish();
      end
   endtask : bound
   task automatic tick;
      @(posedge I_CLK);
      #2;
   endtask : tick
   function automatic logic [7:0] crc8(input logic [15:0] w);
      logic [7:0] c;
      c = 8'hFF;
      for (int i = 15; i >= 0; i--)
         c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
      return c;
   endfunction : crc8
   task automatic send(input logic gc, input logic [7:0] code);
      tick();
      I_CMD = '{1'b1, gc, code};
      tick();
      I_CMD.valid = 1'b0;
   endtask : send
   task automatic hdr(input logic [1:0] kind);
      notes.push_back({kind, 8'h00});
      tick();
      I_RD_HDR = 1'b1;
      tick();
      I_RD_HDR = 1'b0;
   endtask : hdr
   task automatic word(input logic [15:0] w);
      notes.push_back({2'h0, w[15:8]});
      notes.push_back({2'h0, w[7:0]});
      notes.push_back({2'h0, crc8(w)});
   endtask : word
   // Requests run back to back, the hardest spacing allowed
   task automatic read(input integer cnt);
      tick();
      I_BYTE_REQ = 1'b1;
      repeat (cnt) tick();
      I_BYTE_REQ = 1'b0;
   endtask : read
   task automatic idle_wait;
      for (n = 0; O_BUSY !== 1'b0 && n < 50; n++) tick();
      bound(50);
   endtask : idle_wait
   task automatic heat_run(input integer k);
      // Any raw word is legal; the host converts, may clip, may use 2^16
      temp = 16'($random(seed));
      hum = 16'($random(seed));
      dly = 4'(($random(seed) & 7) + 1);
      send(1'b0, codes[k]);
      chk(32'({O_HEAT, O_BUSY}), 32'({1'b1, pwrs[k], 1'b1}));
      hdr(2'h2);
      // Two edges already spent on the refused header
      for (n = 2; O_MEAS_START !== 1'b1 && n < 100; n++) begin
         @(posedge I_CLK);
         #1;
         chk(32'(O_HEAT.en), 32'h1);
      end
      bound(100);
      chk(32'(n), (k % 2 == 0) ? 32'(NL) : 32'(NS));
      for (n = 0; I_MEAS.done !== 1'b1 && n < 40; n++) begin
         @(posedge I_CLK);
         #3;
         chk(32'(O_HEAT), 32'({1'b1, pwrs[k]}));
      end
      bound(40);
      @(posedge I_CLK);
      #1;
      chk(32'({O_HEAT, O_BUSY}), 32'h0);
      hdr(2'h1);
      word(temp);
      word(hum);
      notes.push_back({2'h0, rhc_pkg::IDLE_BYTE});
      read(7);
      hdr(2'h2);
   endtask : heat_run
   // ******************************************************************
   // Result monitor: oldest note against each answer
   // ******************************************************************
   always @(posedge I_CLK) begin
      #1;
      if (O_BYTE.valid === 1'b1 || O_HDR_ACK === 1'b1 || O_HDR_NACK === 1'b1) begin
         seen = (O_BYTE.valid === 1'b1) ? {2'h0, O_BYTE.data} :
                (O_HDR_ACK === 1'b1) ? 10'h100 : 10'h200;
         if (notes.size() == 0)
            chk(32'(seen), 32'h3FF);
         else
            chk(32'(seen), 32'(notes.pop_front()));
      end
   end
   initial begin
      #2_000_000;
      num_errors++;
      $display("ERROR %0t got %h exp %h", $time, 1'b0, 1'b1);
      tally_and_finish();
   end
   // Main sequence
   initial begin
      I_RST = 1'b1;
      I_CMD = '{1'b0, 1'b0, 8'h00};
      I_RD_HDR = 1'b0;
      I_BYTE_REQ = 1'b0;
      temp = 16'h0000;
      hum = 16'h0000;
      dly = 4'h1;
      repeat (16) @(posedge I_CLK);
      #2;
      chk(32'({O_HEAT, O_BUSY, O_BYTE}), 32'({4'h0, 1'b0, 8'hFF}));
      I_RST = 1'b0;
      hdr(2'h2);
      for (int k = 0; k < 6; k++) heat_run(k);
      // Long cool-down keeps total heater on-time under a tenth of the run
      repeat (1500) tick();
      send(1'b0, rhc_pkg::CMD_SERIAL);
      idle_wait();
      hdr(2'h1);
      word(SN[31:16]);
      word(SN[15:0]);
      read(6);
      // Plain measurements at all three repeatabilities, header refused meanwhile
      for (int k = 0; k < 3; k++) begin
         temp = 16'($random(seed));
         hum = 16'($random(seed));
         send(1'b0, mcodes[k]);
         chk(32'({O_HEAT, O_BUSY, O_MEAS_START}), 32'h3);
         hdr(2'h2);
         idle_wait();
         hdr(2'h1);
         word(temp);
         word(hum);
         read(6);
      end
      // Abort in mid countdown; a stray general-call byte must not abort
      send(1'b0, rhc_pkg::CMD_H200_LONG);
      repeat (3) tick();
      send(1'b1, rhc_pkg::CMD_SOFT_RESET);
      chk(32'(O_HEAT), 32'({1'b1, rhc_pkg::PWR_200MW}));
      send(1'b0, rhc_pkg::CMD_SOFT_RESET);
      chk(32'({O_HEAT, O_BUSY}), 32'h0);
      hdr(2'h2);
      send(1'b0, rhc_pkg::CMD_SERIAL);
      idle_wait();
      send(1'b1, rhc_pkg::CMD_GC_RESET);
      hdr(2'h2);
      // Power-down style reset in mid heating
      send(1'b0, rhc_pkg::CMD_H20_SHORT);
      tick();
      I_RST = 1'b1;
      tick();
      chk(32'({O_HEAT, O_BUSY}), 32'h0);
      I_RST = 1'b0;
      hdr(2'h2);
      repeat (4) tick();
      chk(32'(notes.size()), 32'h0);
      tally_and_finish();
   end
endmodule : rhc_core_tb
